// *** hdl/hmx_top.sv ***
// Purpose: Serial slave front end for the hex 2:1 mux switch controller
// Assumes: SCL and SDA are slow against CLK and sampled by it
// Notes: Open-drain SDA, enable low while pulling the line low
//
// How it works
// R1 - Never both switches of one mux closed
// R2 - Later command to a switch replaces earlier
// R3 - Top bit is state; code 0 all A
// R4 - Code 1 drives all B switches
// R5 - Codes 2 to 13 single switches
// R6 - Codes 14 to 19 disable one mux
// R7 - Reserved codes change nothing; 31 off disables
// R8 - Commands queued until a load flagged write
// R9 - Load flag applies this command immediately
// R10 - Host flags only the last batch command
// R11 - Whole batch switches at one moment
// R12 - Power-up or reset flag low opens all
// R13 - Host keeps reset flag high normally
// R14 - Read returns two status bytes with acks
// R15 - Status bit one means switch closed
// R16 - Write word is command then control byte
// R17 - Address upper five fixed, two from pins

`timescale 1ns/10ps

module hmx_top (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic ADDR_SELECT_HIGH_PIN,
  input wire logic ADDR_SELECT_LOW_PIN,
  output logic [5:0] SWITCH_A_ON,
  output logic [5:0] SWITCH_B_ON
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_s3_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_s3_q;
  logic [1:0] asel_s1_q;
  logic [1:0] asel_s2_q;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= SCL;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      sda_s1_q <= SDA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      asel_s1_q <= 2'h0;
      asel_s2_q <= 2'h0;
    end else begin
      asel_s1_q <= {ADDR_SELECT_HIGH_PIN, ADDR_SELECT_LOW_PIN};
      asel_s2_q <= asel_s1_q;
    end
  end

  // ****************************************************************
  // Bus events
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] own_addr;

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_cond = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  // R17 fixed upper bits plus pins
  assign own_addr = {hmx_pkg::ADDR_UPPER, asel_s2_q};

  // ****************************************************************
  // Engine link
  // ****************************************************************
  hmx_cmd_if cmd_if ();

  hmx_engine u_engine (
    .clk(CLK),
    .srst(SRST),
    .cmd(cmd_if.dst)
  );

  // ****************************************************************
  // Protocol state
  // ****************************************************************
  hmx_pkg::hmx_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] tx_next;
  logic byte_idx_q;
  logic nack_q;
  logic [7:0] cmd_byte_q;
  logic [7:0] ctrl_byte_q;
  logic cmd_valid_q;
  logic [7:0] stat_hi_q;
  logic oe_n_q;

  assign tx_next = {tx_q[6:0], 1'b0};

  // Bit counting and shift-in on rising SCL
  always_ff @(posedge CLK) begin
    if (SRST || start_cond || stop_cond) begin
      bit_cnt_q <= 4'h0;
      shift_q <= hmx_pkg::BYTE_RESET;
    end else if (scl_fall && bit_cnt_q == hmx_pkg::BIT_COUNT_FULL) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise && (state_q == hmx_pkg::ST_ADDR ||
        state_q == hmx_pkg::ST_WR_DATA ||
        state_q == hmx_pkg::ST_RD_DATA)) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q <= {shift_q[6:0], sda_s2_q};
    end
  end

  // Master acknowledge during read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      nack_q <= 1'b1;
    end else if (scl_rise && state_q == hmx_pkg::ST_RD_ACK) begin
      nack_q <= sda_s2_q;
    end
  end

  // Main sequencer
  always_ff @(posedge CLK) begin
    if (SRST || stop_cond) begin
      state_q <= hmx_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_q <= hmx_pkg::ST_ADDR;
    end else if (scl_fall) begin
      case (state_q)
        hmx_pkg::ST_ADDR: begin
          if (bit_cnt_q == hmx_pkg::BIT_COUNT_FULL) begin
            state_q <= (shift_q[7:1] == own_addr) ?
              hmx_pkg::ST_ADDR_ACK : hmx_pkg::ST_SKIP;
          end
        end
        hmx_pkg::ST_ADDR_ACK: begin
          state_q <= shift_q[0] ? hmx_pkg::ST_RD_DATA : hmx_pkg::ST_WR_DATA;
        end
        hmx_pkg::ST_WR_DATA: begin
          if (bit_cnt_q == hmx_pkg::BIT_COUNT_FULL) begin
            state_q <= hmx_pkg::ST_WR_ACK;
          end
        end
        hmx_pkg::ST_WR_ACK: begin
          state_q <= hmx_pkg::ST_WR_DATA;
        end
        hmx_pkg::ST_RD_DATA: begin
          if (bit_cnt_q == hmx_pkg::BIT_COUNT_FULL) begin
            state_q <= hmx_pkg::ST_RD_ACK;
          end
        end
        hmx_pkg::ST_RD_ACK: begin
          state_q <= nack_q ? hmx_pkg::ST_SKIP : hmx_pkg::ST_RD_DATA;
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // R16 command byte then control byte
  always_ff @(posedge CLK) begin
    if (SRST || start_cond) begin
      byte_idx_q <= 1'b0;
    end else if (scl_fall && bit_cnt_q == hmx_pkg::BIT_COUNT_FULL &&
        (state_q == hmx_pkg::ST_WR_DATA ||
        state_q == hmx_pkg::ST_RD_DATA)) begin
      byte_idx_q <= ~byte_idx_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_byte_q <= hmx_pkg::BYTE_RESET;
      ctrl_byte_q <= hmx_pkg::BYTE_RESET;
    end else if (scl_fall && bit_cnt_q == hmx_pkg::BIT_COUNT_FULL &&
        state_q == hmx_pkg::ST_WR_DATA) begin
      if (byte_idx_q) begin
        ctrl_byte_q <= shift_q;
      end else begin
        cmd_byte_q <= shift_q;
      end
    end
  end

  // Strobe once the second byte is complete
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= scl_fall && bit_cnt_q == hmx_pkg::BIT_COUNT_FULL &&
        state_q == hmx_pkg::ST_WR_DATA && byte_idx_q;
    end
  end

  assign cmd_if.cmd_valid = cmd_valid_q;
  assign cmd_if.cmd_byte = cmd_byte_q;
  assign cmd_if.ctrl_byte = ctrl_byte_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // R15 one for closed switch
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tx_q <= hmx_pkg::BYTE_RESET;
      stat_hi_q <= hmx_pkg::BYTE_RESET;
    end else if (scl_fall && state_q == hmx_pkg::ST_ADDR_ACK) begin
      tx_q <= {2'b00, cmd_if.sw_a};
      stat_hi_q <= {2'b00, cmd_if.sw_b};
    end else if (scl_fall && state_q == hmx_pkg::ST_RD_ACK) begin
      tx_q <= stat_hi_q;
    end else if (scl_fall && state_q == hmx_pkg::ST_RD_DATA) begin
      tx_q <= tx_next;
    end
  end

  // ****************************************************************
  // SDA drive
  // ****************************************************************
  // R14 acks and two status bytes
  always_ff @(posedge CLK) begin
    if (SRST || start_cond || stop_cond) begin
      oe_n_q <= 1'b1;
    end else if (scl_fall) begin
      case (state_q)
        hmx_pkg::ST_ADDR: begin
          oe_n_q <= !(bit_cnt_q == hmx_pkg::BIT_COUNT_FULL &&
            shift_q[7:1] == own_addr);
        end
        hmx_pkg::ST_ADDR_ACK: begin
          // Read starts with the zero top bit of byte0
          oe_n_q <= !shift_q[0];
        end
        hmx_pkg::ST_WR_DATA: begin
          oe_n_q <= !(bit_cnt_q == hmx_pkg::BIT_COUNT_FULL);
        end
        hmx_pkg::ST_RD_DATA: begin
          oe_n_q <= (bit_cnt_q == hmx_pkg::BIT_COUNT_FULL) ? 1'b1 :
            tx_next[7];
        end
        hmx_pkg::ST_RD_ACK: begin
          oe_n_q <= nack_q ? 1'b1 : stat_hi_q[7];
        end
        default: begin
          oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SDA_OUT <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE_N <= oe_n_q;
    end
  end

  // ****************************************************************
  // Switch outputs
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SWITCH_A_ON <= hmx_pkg::SWITCHES_RESET;
      SWITCH_B_ON <= hmx_pkg::SWITCHES_RESET;
    end else begin
      SWITCH_A_ON <= cmd_if.sw_a;
      SWITCH_B_ON <= cmd_if.sw_b;
    end
  end

endmodule : hmx_top

// *** hdl/hmx_pkg.sv ***
// Purpose: Shared constants and types for the hex mux command controller
// Assumes: Command word is two bytes, status read is two bytes
// Notes: Bit positions of the mode flags are fixed here

package hmx_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_MUX = 6;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;

  // ****************************************************************
  // Slave address
  // ****************************************************************
  localparam logic [4:0] ADDR_UPPER = 5'h14;

  // ****************************************************************
  // Second command byte field positions
  // ****************************************************************
  localparam int LOAD_SWITCHES_FLAG_POS = 1;
  localparam int SOFT_RESET_LOW_FLAG_POS = 0;

  // ****************************************************************
  // First command byte fields and selector codes
  // ****************************************************************
  localparam int SWITCH_STATE_BIT_POS = 7;
  localparam logic [6:0] SEL_ALL_A = 7'h00;
  localparam logic [6:0] SEL_ALL_B = 7'h01;
  localparam logic [6:0] SEL_SINGLE_FIRST = 7'h02;
  localparam logic [6:0] SEL_DISABLE_FIRST = 7'h0e;
  localparam logic [6:0] SEL_ALL_DISABLE = 7'h1f;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [5:0] SWITCHES_RESET = 6'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [5:0] mask_a;
    logic [5:0] mask_b;
    logic [5:0] val_a;
    logic [5:0] val_b;
  } hmx_upd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_DATA = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_DATA = 3'h7,
    ST_RD_ACK = 3'h5,
    ST_SKIP = 3'h4
  } hmx_state_t;

endpackage : hmx_pkg

// *** hdl/hmx_cmd_if.sv ***
// Purpose: Carrier between the serial front end and the switch engine
// Assumes: Single clock domain
// Notes: One-cycle command strobe, switch state returned as levels

`timescale 1ns/10ps

interface hmx_cmd_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic [7:0] ctrl_byte;
  logic [5:0] sw_a;
  logic [5:0] sw_b;

  modport src (output cmd_valid, output cmd_byte, output ctrl_byte,
    input sw_a, input sw_b);
  modport dst (input cmd_valid, input cmd_byte, input ctrl_byte,
    output sw_a, output sw_b);
endinterface : hmx_cmd_if

// *** hdl/hmx_engine.sv ***
// Purpose: Queues switch commands and applies them as one batch
// Assumes: Command strobe arrives once per complete two-byte word
// Notes: Holds the applied switch state in flip-flops

`timescale 1ns/10ps

module hmx_engine (
  input wire logic clk,
  input wire logic srst,
  hmx_cmd_if.dst cmd
);

  // ****************************************************************
  // Command decode
  // ****************************************************************
  function automatic hmx_pkg::hmx_upd_t decode_cmd(input logic [7:0] c);
    hmx_pkg::hmx_upd_t u;
    logic on;
    logic [6:0] sel;
    u = '0;
    on = c[hmx_pkg::SWITCH_STATE_BIT_POS];
    sel = c[6:0];
    // R3 all A side
    if (sel == hmx_pkg::SEL_ALL_A) begin
      u.mask_a = 6'h3f;
      u.val_a = on ? 6'h3f : 6'h00;
      // R1 closing A opens B
      u.mask_b = on ? 6'h3f : 6'h00;
    // R4 all B side
    end else if (sel == hmx_pkg::SEL_ALL_B) begin
      u.mask_b = 6'h3f;
      u.val_b = on ? 6'h3f : 6'h00;
      u.mask_a = on ? 6'h3f : 6'h00;
    // R7 disable all, reserved when set
    end else if (sel == hmx_pkg::SEL_ALL_DISABLE) begin
      if (!on) begin
        u.mask_a = 6'h3f;
        u.mask_b = 6'h3f;
      end
    end else begin
      for (int i = 0; i < hmx_pkg::NUM_MUX; i++) begin
        // R5 single switch codes
        if (sel == 7'(hmx_pkg::SEL_SINGLE_FIRST + 2 * i)) begin
          u.mask_a[i] = 1'b1;
          u.val_a[i] = on;
          // R1 partner opened
          u.mask_b[i] = on;
        end
        if (sel == 7'(hmx_pkg::SEL_SINGLE_FIRST + 2 * i + 1)) begin
          u.mask_b[i] = 1'b1;
          u.val_b[i] = on;
          u.mask_a[i] = on;
        end
        // R6 disable one mux
        if (sel == 7'(hmx_pkg::SEL_DISABLE_FIRST + i)) begin
          u.mask_a[i] = 1'b1;
          u.mask_b[i] = 1'b1;
        end
      end
    end
    return u;
  endfunction : decode_cmd

  // ****************************************************************
  // Pending merge
  // ****************************************************************
  hmx_pkg::hmx_upd_t pend_q;
  hmx_pkg::hmx_upd_t pend_d;
  hmx_pkg::hmx_upd_t upd;
  logic [5:0] sw_a_q;
  logic [5:0] sw_b_q;
  logic load_switches_flag;
  logic rst_low;

  assign upd = decode_cmd(cmd.cmd_byte);
  assign load_switches_flag = cmd.ctrl_byte[hmx_pkg::LOAD_SWITCHES_FLAG_POS];
  assign rst_low = ~cmd.ctrl_byte[hmx_pkg::SOFT_RESET_LOW_FLAG_POS];

  // R2 latest command wins
  always_comb begin
    pend_d.mask_a = pend_q.mask_a | upd.mask_a;
    pend_d.mask_b = pend_q.mask_b | upd.mask_b;
    pend_d.val_a = (pend_q.val_a & ~upd.mask_a) | (upd.val_a & upd.mask_a);
    pend_d.val_b = (pend_q.val_b & ~upd.mask_b) | (upd.val_b & upd.mask_b);
  end

  // R8 queue until load
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= '0;
    end else if (cmd.cmd_valid) begin
      if (rst_low || load_switches_flag) begin
        pend_q <= '0;
      end else begin
        pend_q <= pend_d;
      end
    end
  end

  // R12 power-up and soft reset open all
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_a_q <= hmx_pkg::SWITCHES_RESET;
      sw_b_q <= hmx_pkg::SWITCHES_RESET;
    end else if (cmd.cmd_valid && rst_low) begin
      sw_a_q <= hmx_pkg::SWITCHES_RESET;
      sw_b_q <= hmx_pkg::SWITCHES_RESET;
    // R9 R11 batch applied at once
    end else if (cmd.cmd_valid && load_switches_flag) begin
      sw_a_q <= (sw_a_q & ~pend_d.mask_a) | (pend_d.val_a & pend_d.mask_a);
      sw_b_q <= (sw_b_q & ~pend_d.mask_b) | (pend_d.val_b & pend_d.mask_b);
    end
  end

  assign cmd.sw_a = sw_a_q;
  assign cmd.sw_b = sw_b_q;

endmodule : hmx_engine

// *** sim/hmx_i2c_master.sv ***
// Purpose: Serial bus master model for the switch controller
// Assumes: Pull-up on the data wire, bit period 8 CLK (160 ns)
// Notes: Clock wire stands high between frames

`timescale 1ns/10ps

module hmx_i2c_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w

  task start;
    sda_low = 1'b0;
    w(4);
    scl = 1'b1;
    w(4);
    sda_low = 1'b1;
    w(4);
    scl = 1'b0;
  endtask : start

  task stop;
    w(2);
    sda_low = 1'b1;
    w(4);
    scl = 1'b1;
    w(4);
    sda_low = 1'b0;
    w(4);
  endtask : stop

  task xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      w(2);
      sda_low = ~d[i];
      w(4);
      scl = 1'b1;
      w(2);
      q[i] = sda;
      scl = 1'b0;
    end
  endtask : xfer
endmodule : hmx_i2c_master

// *** sim/hmx_checker.sv ***
// Purpose: Port assertions for the switch controller
// Assumes: Single clock domain
// Notes: Bound to hmx_top

`timescale 1ns/10ps

module hmx_checker (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic ADDR_SELECT_HIGH_PIN,
  input wire logic ADDR_SELECT_LOW_PIN,
  input wire logic [5:0] SWITCH_A_ON,
  input wire logic [5:0] SWITCH_B_ON
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  AST_ONE_PER_MUX: assert property (
    (SWITCH_A_ON & SWITCH_B_ON) == 6'h00) else $error("both sides on");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    SRST |=> SDA_OE_N && SWITCH_A_ON == 6'h00 && SWITCH_B_ON == 6'h00)
    else $error("reset did not open all");
  AST_SW_AT_ACK: assert property (
    $changed({SWITCH_A_ON, SWITCH_B_ON}) |-> !SDA_OE_N)
    else $error("switch change outside ack");
  AST_SW_BATCH: assert property (
    $changed({SWITCH_A_ON, SWITCH_B_ON}) |=>
      $stable({SWITCH_A_ON, SWITCH_B_ON})[*8])
    else $error("switch update split");
  AST_OE_AFTER_FALL: assert property (
    $changed(SDA_OE_N) |-> !SCL && !$past(SCL, 2))
    else $error("data drive moved with clock high");
  AST_OE_STEADY_HIGH: assert property (
    SCL && $past(SCL) |-> $stable(SDA_OE_N))
    else $error("data drive changed while clock high");
  AST_OE_BOUNDED: assert property (
    $fell(SDA_OE_N) |-> ##[1:100] $rose(SDA_OE_N))
    else $error("data line held too long");
  AST_SDA_OUT_LOW: assert property (
    SDA_OUT == 1'b0) else $error("open drain output high");

  cover property ($changed(SWITCH_A_ON));
  cover property ($fell(SDA_OE_N));
  cover property (SWITCH_B_ON == 6'h3f);
endmodule : hmx_checker

bind hmx_top hmx_checker u_chk (.CLK(CLK), .SRST(SRST), .SCL(SCL),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .ADDR_SELECT_HIGH_PIN(ADDR_SELECT_HIGH_PIN),
  .ADDR_SELECT_LOW_PIN(ADDR_SELECT_LOW_PIN),
  .SWITCH_A_ON(SWITCH_A_ON), .SWITCH_B_ON(SWITCH_B_ON));

// *** sim/hmx_top_tb_top.sv ***
// Purpose: Self-checking bench for the switch controller
// Assumes: Random commands from a fixed seed
// Notes: Expected switch state kept as applied plus pending masks

`timescale 1ns/10ps

module hmx_top_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ahi = 1'b0;
  logic alo = 1'b0;
  logic scl, m_low, sda_oe_n, sda_out, sda;
  logic [5:0] sw_a, sw_b, ea, eb, ma, va, mb, vb;
  logic [8:0] q;
  logic [7:0] c;
  logic [31:0] r;
  integer seed = 32'hacf5;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;
  assign sda = (sda_oe_n | sda_out) & ~m_low;

  hmx_top uut (.CLK(clk), .SRST(srst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_SELECT_HIGH_PIN(ahi),
    .ADDR_SELECT_LOW_PIN(alo), .SWITCH_A_ON(sw_a), .SWITCH_B_ON(sw_b));
  hmx_i2c_master u_m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  task end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      end_of_test();
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  function automatic void put(input logic sb, input logic [5:0] m,
    input logic on);
    logic [5:0] v;
    v = on ? m : 6'h00;
    if (sb) begin
      mb = mb | m;
      vb = (vb & ~m) | v;
    end else begin
      ma = ma | m;
      va = (va & ~m) | v;
    end
  endfunction : put

  function automatic void qcmd(input logic [7:0] cmd);
    logic [6:0] s;
    logic [5:0] m;
    s = cmd[6:0];
    m = 6'h01 << ((s - 7'h02) >> 1);
    if (s < 7'h0e) begin
      if (s < 7'h02) m = 6'h3f;
      put(s[0], m, cmd[7]);
      if (cmd[7]) put(!s[0], m, 1'b0);
    end else if (s < 7'h14 || cmd == 8'h1f) begin
      m = (s < 7'h14) ? 6'h01 << (s - 7'h0e) : 6'h3f;
      put(1'b0, m, 1'b0);
      put(1'b1, m, 1'b0);
    end
  endfunction : qcmd

  task automatic addr(input logic rd, input logic [1:0] pins,
    input logic ack);
    u_m.start();
    u_m.xfer({hmx_pkg::ADDR_UPPER, pins, rd, 1'b1}, q);
    check({7'h00, q[0]}, {7'h00, !ack});
  endtask : addr

  task automatic word(input logic [7:0] cmd, input logic ld,
    input logic rn);
    c = 8'h00;
    c[hmx_pkg::LOAD_SWITCHES_FLAG_POS] = ld;
    c[hmx_pkg::SOFT_RESET_LOW_FLAG_POS] = rn;
    u_m.xfer({cmd, 1'b1}, q);
    check({7'h00, q[0]}, 8'h00);
    u_m.xfer({c, 1'b1}, q);
    check({7'h00, q[0]}, 8'h00);
    if (rn) qcmd(cmd);
    if (!rn || ld) begin
      ea = rn ? (ea & ~ma) | (va & ma) : 6'h00;
      eb = rn ? (eb & ~mb) | (vb & mb) : 6'h00;
      ma = 6'h00;
      mb = 6'h00;
    end
  endtask : word

  task automatic status;
    addr(1'b1, {ahi, alo}, 1'b1);
    u_m.xfer(9'h1fe, q);
    check(q[8:1], {2'b00, ea});
    u_m.xfer(9'h1ff, q);
    check(q[8:1], {2'b00, eb});
    u_m.stop();
    check({2'b00, sw_a}, {2'b00, ea});
    check({2'b00, sw_b}, {2'b00, eb});
  endtask : status

  initial begin
    {ea, eb, ma, va, mb, vb} = 36'h0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    status();
    // Selector codes 0 to 31 with both state bits
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      addr(1'b0, {ahi, alo}, 1'b1);
      word({1'b1, 3'h0, r[3:0]}, 1'b1, 1'b1);
      word({i[0], 2'b00, i[5:1]}, 1'b1, 1'b1);
      u_m.stop();
      status();
    end
    // Batches, with a wrong address first
    for (int n = 0; n < 12; n++) begin
      r = $random(seed);
      {ahi, alo} = r[9:8];
      addr(1'b0, r[9:8] ^ 2'b01, 1'b0);
      u_m.stop();
      addr(1'b0, r[9:8], 1'b1);
      for (int k = 0; k < 4; k++) begin
        r = $random(seed);
        word({r[7], 2'b00, r[4:0]}, 1'b0, 1'b1);
      end
      u_m.stop();
      status();
      r = $random(seed);
      addr(1'b0, {ahi, alo}, 1'b1);
      word({r[7], 2'b00, r[4:0]}, 1'b1, 1'b1);
      u_m.stop();
      status();
    end
    // Reset flag clears state and queue
    addr(1'b0, {ahi, alo}, 1'b1);
    word(8'h82, 1'b1, 1'b1);
    word(8'h85, 1'b0, 1'b1);
    word(8'h80, 1'b1, 1'b0);
    word(8'h94, 1'b1, 1'b1);
    u_m.stop();
    status();
    addr(1'b0, {ahi, alo}, 1'b1);
    word(8'h81, 1'b1, 1'b1);
    u_m.stop();
    status();
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    {ea, eb, ma, mb} = 24'h0;
    repeat (4) @(posedge clk);
    #1;
    status();
    end_of_test();
  end
endmodule : hmx_top_tb_top
